// File: dv/diskette_drive_interface_control_tb.sv
// Purpose: Self-checking bench for the diskette drive control block
// Assumes: Index pulse shortened to IDX cycles
// Notes:   Track count is mirrored in an integer model
`timescale 1ns/1ps
module diskette_drive_interface_control_tb;
    import drive_iface_pkg::*;
    localparam int unsigned IDX = 20;
    logic        clk_sys = 1'h0, rst_n = 1'h0;
    logic        holeSense = 1'h0, fluxSense = 1'h0;
    logic [3:0]  select_n;
    logic        motorOn_n, direction_n, step_n, writeGate_n;
    logic        writeData_n, sideOne_n, inUse_n, wc;
    logic        trackZero_n, indexSector_n, writeProtect_n, readData_n;
    logic        spindleRun, headStepPulse, headStepIn, upperHead;
    logic        writeCurrent, writeEnable, lampOn;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          err_count = 0, compares = 0, trk = 0, n, c;

    always #25 clk_sys = !clk_sys;

    host_ctrl_model hm_u (.clk_sys, .select_n, .motorOn_n, .direction_n,
        .step_n, .writeGate_n, .writeData_n, .sideOne_n, .inUse_n);

    diskette_drive_interface_control #(.IDX_PULSE_CYC(IDX)) dut_u (.clk_sys,
        .rst_n, .select_n, .motorOn_n, .direction_n, .step_n, .writeGate_n,
        .writeData_n, .sideOne_n, .inUse_n, .trackZero_n, .indexSector_n,
        .writeProtect_n, .readData_n, .holeSense, .fluxSense, .spindleRun,
        .headStepPulse, .headStepIn, .upperHead, .writeCurrent, .writeEnable,
        .lampOn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Holds every valid until its own ready, answer taken at the same edge
    task automatic axi(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        do
        begin
            @(posedge clk_sys);
            k++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            q = s_axi_rdata;
            r = wr ? s_axi_bresp : s_axi_rresp;
        end
        while (!(wr ? s_axi_bvalid : s_axi_rvalid) && k < 200);
        if (k >= 200) err_count++;
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        @(posedge clk_sys);
    endtask : axi

    // One hole or flux edge, then count low cycles on the matching output
    task automatic pulse(input logic idx);
        c = 0;
        if (idx) holeSense <= 1'h1;
        else fluxSense <= !fluxSense;
        for (int k = 0; k < 50; k++)
        begin
            @(posedge clk_sys);
            if (k == 2) holeSense <= 1'h0;
            c += idx ? !indexSector_n : !readData_n;
        end
    endtask : pulse

    task finish_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    initial
    begin
        #2_000_000;
        err_count++;
        finish_test();
    end

    initial
    begin
        void'($urandom(32'hBF907101));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'h1;
        axi(1'h0, REG_CTRL, 32'h0);
        chk("ctrl", CTRL_RESET, q);
        axi(1'h0, 8'h10, 32'h0);
        chk("unmapped", {30'h0, RESP_SLVERR}, {q[29:0], r});
        axi(1'h1, REG_STATUS, 32'h0);
        chk("status write", RESP_SLVERR, r);
        hm_u.drive(4'hD, 1'h0, 1'h1, 1'h1, 1'h1);
        chk("spindleRun", 1, spindleRun);
        n = 1 + $urandom % 4;
        for (int i = 0; i < 2 * n + 2; i++)
        begin
            hm_u.step(i < n);
            trk = (i < n) ? trk + 1 : (trk > 0 ? trk - 1 : 0);
            chk("trackZero_n", trk != 0, trackZero_n);
            axi(1'h0, REG_TRACK, 32'h0);
            chk("track", trk, q);
        end
        hm_u.drive(4'hD, 1'h0, 1'h0, 1'h1, 1'h1);
        chk("writeEnable", 1, writeEnable);
        wc = writeCurrent;
        repeat (3) hm_u.wbit();
        chk("writeCurrent", !wc, writeCurrent);
        hm_u.step(1'h1);
        pulse(1'h0);
        axi(1'h0, REG_TRACK, 32'h0);
        chk("gated step and read", trk, q + c);
        axi(1'h1, REG_CTRL, 32'h11);
        chk("ctrl write", RESP_OKAY, r);
        wc = writeCurrent;
        hm_u.wbit();
        chk("writeProtect_n", 0, writeProtect_n);
        chk("protected", {wc, 1'h0}, {writeCurrent, writeEnable});
        hm_u.drive(4'hD, 1'h0, 1'h1, 1'h0, 1'h1);
        chk("upperHead", 1, upperHead);
        axi(1'h0, REG_STATUS, 32'h0);
        chk("status", {26'h0, 4'hB, 1'h0, trk == 0}, q);
        axi(1'h0, REG_EVENTS, 32'h0);
        chk("events", {21'h0, ~{select_n, motorOn_n, direction_n, step_n,
            writeGate_n, writeData_n, sideOne_n, inUse_n}}, q);
        pulse(1'h0);
        chk("read low", DATA_LOW_CYC, c);
        pulse(1'h1);
        chk("index low", IDX, c);
        n = 0;
        repeat (3)
        begin
            pulse(1'h1);
            n += c;
        end
        chk("sector low", 3 * IDX, n);
        hm_u.drive(4'hE, 1'h0, 1'h1, 1'h1, 1'h0);
        chk("lampOn", 1, lampOn);
        chk("deselected", 4'hF, {trackZero_n, indexSector_n,
            writeProtect_n, readData_n});
        hm_u.step(1'h1);
        pulse(1'h1);
        axi(1'h0, REG_TRACK, 32'h0);
        chk("other line", trk, q + c);
        // Lamp input idle again so the reset below leaves lamp and pin agreed
        hm_u.drive(4'hE, 1'h0, 1'h1, 1'h1, 1'h1);
        chk("lamp off", 0, lampOn);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        axi(1'h0, REG_CTRL, 32'h0);
        chk("ctrl again", CTRL_RESET, q);
        finish_test();
    end
endmodule : diskette_drive_interface_control_tb

// File: dv/drive_iface_monitor.sv
// Purpose: Port checks for the diskette drive control block
// Assumes: CTRL stays on select line one
// Notes:   Input sync latency taken as six cycles at most
`timescale 1ns/1ps
module drive_iface_monitor
#(
    parameter int unsigned IDX_PULSE_CYC = 20
)
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // Cable
    input wire logic [3:0] select_n,
    input wire logic       motorOn_n,
    input wire logic       direction_n,
    input wire logic       step_n,
    input wire logic       writeGate_n,
    input wire logic       sideOne_n,
    input wire logic       inUse_n,
    input wire logic       trackZero_n,
    input wire logic       indexSector_n,
    input wire logic       writeProtect_n,
    input wire logic       readData_n,
    // Mechanics and bus
    input wire logic       spindleRun,
    input wire logic       headStepPulse,
    input wire logic       headStepIn,
    input wire logic       upperHead,
    input wire logic       writeEnable,
    input wire logic       lampOn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready
);
    int unsigned lowCnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || indexSector_n)
            lowCnt <= 0;
        else
            lowCnt <= lowCnt + 1;
    end

    sequence stepEdge;
        $rose(step_n) && !select_n[1] && writeGate_n;
    endsequence
    sequence deselHeld;
        select_n[1] [*6];
    endsequence

    a_step_moves: assert property (
        stepEdge ##0 (!direction_n || trackZero_n) |-> ##[2:8] headStepPulse)
        else $error("step lost");
    a_step_single: assert property (
        headStepPulse |=> !headStepPulse [*8]) else $error("double step");
    a_step_gated: assert property (
        (!writeGate_n || select_n[1]) [*8] |-> !headStepPulse)
        else $error("gated step");
    a_zero_after_in: assert property (
        headStepPulse && headStepIn |=> trackZero_n) else $error("zero flag");
    a_zero_holds: assert property (
        headStepPulse && !trackZero_n |-> headStepIn) else $error("below zero");
    a_idx_width: assert property (
        $rose(indexSector_n) |-> lowCnt == IDX_PULSE_CYC)
        else $error("index width");
    a_wp_inhibit: assert property (
        !writeProtect_n && !$past(writeProtect_n) |-> !writeEnable)
        else $error("protected write");
    a_lamp_ungated: assert property (
        $stable(inUse_n) [*6] |-> lampOn == !inUse_n) else $error("lamp");
    a_motor_run: assert property (
        (!select_n[1] && $stable(motorOn_n)) [*6] |-> spindleRun == !motorOn_n)
        else $error("spindle");
    a_side_head: assert property (
        (!select_n[1] && $stable(sideOne_n)) [*6] |-> upperHead == !sideOne_n)
        else $error("head side");
    a_gated_out: assert property (
        deselHeld |-> trackZero_n && indexSector_n && writeProtect_n
        && readData_n) else $error("deselected output");
    a_resp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped");
endmodule : drive_iface_monitor

bind diskette_drive_interface_control drive_iface_monitor
    #(.IDX_PULSE_CYC(IDX_PULSE_CYC)) mon_u (.clk_sys, .rst_n, .select_n,
    .motorOn_n, .direction_n, .step_n, .writeGate_n, .sideOne_n, .inUse_n,
    .trackZero_n, .indexSector_n, .writeProtect_n, .readData_n, .spindleRun,
    .headStepPulse, .headStepIn, .upperHead, .writeEnable, .lampOn,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);

// File: dv/host_ctrl_model.sv
// Purpose: Host controller side of the drive cable
// Assumes: Lines idle high through the terminator pull-ups
// Notes:   Motor and step spacing waits are scaled down to keep runs short
`timescale 1ns/1ps
module host_ctrl_model
#(
    parameter int unsigned WIDTH_CYC  = 20,
    parameter int unsigned GAP_CYC    = 40,
    parameter int unsigned SETTLE_CYC = 20,
    parameter int unsigned CELL_CYC   = 160
)
(
    // Clock
    input  wire logic  clk_sys,
    // Cable lines toward the drive, active low
    output logic [3:0] select_n = 4'hF,
    output logic       motorOn_n = 1'h1,
    output logic       direction_n = 1'h1,
    output logic       step_n = 1'h1,
    output logic       writeGate_n = 1'h1,
    output logic       writeData_n = 1'h1,
    output logic       sideOne_n = 1'h1,
    output logic       inUse_n = 1'h1
);
    // One select line low at a time, then wait for speed and side switch
    task drive(input logic [3:0] sel, input logic mot, wg, side, lamp);
        select_n <= sel;
        motorOn_n <= mot;
        writeGate_n <= wg;
        sideOne_n <= side;
        inUse_n <= lamp;
        repeat (SETTLE_CYC) @(posedge clk_sys);
    endtask : drive

    task step(input logic inward);
        direction_n <= !inward;
        repeat (WIDTH_CYC) @(posedge clk_sys);
        step_n <= 1'h0;
        repeat (WIDTH_CYC) @(posedge clk_sys);
        step_n <= 1'h1;
        repeat (GAP_CYC) @(posedge clk_sys);
    endtask : step

    task wbit();
        writeData_n <= 1'h0;
        repeat (5) @(posedge clk_sys);
        writeData_n <= 1'h1;
        repeat (CELL_CYC - 5) @(posedge clk_sys);
    endtask : wbit
endmodule : host_ctrl_model

// File: rtl/diskette_drive_interface_control.sv
// Purpose: Drive-side logic of a single-density diskette drive interface
// Assumes: Cable inputs are asynchronous and active low; rst_n synchronous
// Notes:   Rotation, index holes and flux come from sensor inputs; software
//          configures select line, media type and sensors over AXI4-Lite
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Contract
// - Inputs and outputs act only while selected, except the indicator input
// - Four select lines, drive answers one
// - Spindle runs while motor input low
// - Direction low steps inward, high outward
// - One track move per step, rising edge
// - Write gate low enables writing
// - Write gate high enables stepping and read
// - Indicator input lights lamp, ungated
// - Side input high lower head, low upper
// - Track-zero output low at track zero
// - Outward steps ignored at track zero
// - Single-hole media gives index per turn
// - Multi-hole media adds sector pulses
// - Index and sector pulses low 4ms
// - Write-protect low when no notch
// - Write protect inhibits writing
// - Write data falling edge reverses current
module diskette_drive_interface_control
    import drive_iface_pkg::*;
#(
    parameter int unsigned TRACKS        = 40,
    parameter int unsigned IDX_PULSE_CYC = IDX_WIDTH_CYC
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Cable inputs, active low
    input  wire logic [3:0]  select_n,
    input  wire logic        motorOn_n,
    input  wire logic        direction_n,
    input  wire logic        step_n,
    input  wire logic        writeGate_n,
    input  wire logic        writeData_n,
    input  wire logic        sideOne_n,
    input  wire logic        inUse_n,
    // Cable outputs, active low, open collector style
    output logic             trackZero_n,
    output logic             indexSector_n,
    output logic             writeProtect_n,
    output logic             readData_n,
    // Sensors and mechanics
    input  wire logic        holeSense,
    input  wire logic        fluxSense,
    output logic             spindleRun,
    output logic             headStepPulse,
    output logic             headStepIn,
    output logic             upperHead,
    output logic             writeCurrent,
    output logic             writeEnable,
    output logic             lampOn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    if (TRACKS < 2 || TRACKS > 255 || IDX_PULSE_CYC < 1)
    begin : g_bad_params
        $error("Unsupported drive parameters");
    end

    localparam int N_SYNC = 11;

    // Three-stage sync; a change counts when stages two and three agree
    logic [N_SYNC-1:0] s1;
    logic [N_SYNC-1:0] s2;
    logic [N_SYNC-1:0] s3;
    logic [N_SYNC-1:0] clean;
    logic [N_SYNC-1:0] rawIn;

    assign rawIn = {select_n, motorOn_n, direction_n, step_n, writeGate_n,
                    writeData_n, sideOne_n, inUse_n};

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s1 <= '1;
            s2 <= '1;
            s3 <= '1;
        end
        else
        begin
            s1 <= rawIn;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            clean <= '1;
        else
            for (int i = 0; i < N_SYNC; i++)
                if (s2[i] == s3[i])
                    clean[i] <= s3[i];
    end

    logic [31:0] ctrl;
    logic [1:0]  selLine;
    logic        selected;
    drive_cmd_s  cmd;

    assign selLine  = ctrl[CTRL_SELECT_LSB +: 2];
    assign selected = !clean[7 + selLine];
    assign cmd.motorOn   = !clean[6];
    assign cmd.dirIn     = !clean[5];
    assign cmd.stepLow   = !clean[4];
    assign cmd.writeGate = !clean[3];
    assign cmd.sideOne   = !clean[1];

    // Motor follows its own line; select gating keeps unselected drives still
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            spindleRun <= 1'b0;
        else
            spindleRun <= selected && cmd.motorOn;
    end

    // Step edge detection; move starts at the trailing edge
    logic       stepPrev;
    logic       stepRise;
    logic [7:0] track;
    logic       protect;
    logic       mediaIn;

    assign protect = mediaIn && !ctrl[CTRL_WP_NOTCH];
    assign mediaIn = ctrl[CTRL_MEDIA_IN];

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            stepPrev <= 1'b0;
        else
            stepPrev <= cmd.stepLow && selected;
    end

    assign stepRise = stepPrev && !(cmd.stepLow && selected);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            track         <= 8'h00;
            headStepPulse <= 1'b0;
            headStepIn    <= 1'b0;
        end
        else
        begin
            headStepPulse <= 1'b0;
            if (stepRise && selected && !cmd.writeGate)
            begin
                headStepIn <= cmd.dirIn;
                if (cmd.dirIn)
                begin
                    if (track < 8'(TRACKS - 1))
                    begin
                        track         <= track + 8'h01;
                        headStepPulse <= 1'b1;
                    end
                end
                else if (track != 8'h00)
                begin
                    track         <= track - 8'h01;
                    headStepPulse <= 1'b1;
                end
            end
        end
    end

    // Write path: gate low and no protect, each falling data edge flips
    logic dataPrev;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            writeEnable  <= 1'b0;
            writeCurrent <= 1'b0;
            dataPrev     <= 1'b1;
        end
        else
        begin
            dataPrev    <= clean[2];
            writeEnable <= selected && cmd.writeGate && !protect;
            if (writeEnable && dataPrev && !clean[2])
                writeCurrent <= !writeCurrent;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            upperHead <= 1'b0;
            lampOn    <= 1'b0;
        end
        else
        begin
            if (selected)
                upperHead <= cmd.sideOne;
            lampOn <= !clean[0];
        end
    end

    // Read data: each flux edge while selected with write gate high gives a fixed-width low pulse
    logic [2:0] fluxSync;
    logic       fluxLevel;
    logic       fluxPrev;
    logic [7:0] readCnt;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            fluxSync  <= 3'b000;
            fluxLevel <= 1'b0;
            fluxPrev  <= 1'b0;
            readCnt   <= 8'h00;
        end
        else
        begin
            fluxSync <= {fluxSync[1:0], fluxSense};
            // Sensor is asynchronous: take a level once stages two and three agree
            if (fluxSync[1] == fluxSync[2])
                fluxLevel <= fluxSync[2];
            fluxPrev <= fluxLevel;
            if (fluxLevel != fluxPrev && selected && !cmd.writeGate)
                readCnt <= 8'(DATA_LOW_CYC);
            else if (readCnt != 8'h00)
                readCnt <= readCnt - 8'h01;
        end
    end

    // Index/sector: every hole sensed while the spindle runs with media in becomes one stretched low pulse;
    // single-hole media yields one per turn, the last hole before index
    // of hard-sector media is included since all holes pass through
    logic [2:0]  holeSync;
    logic        holeLevel;
    logic        holePrev;
    logic [31:0] idxCnt;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            holeSync  <= 3'b000;
            holeLevel <= 1'b0;
            holePrev  <= 1'b0;
            idxCnt    <= 32'h0000_0000;
        end
        else
        begin
            holeSync <= {holeSync[1:0], holeSense};
            if (holeSync[1] == holeSync[2])
                holeLevel <= holeSync[2];
            holePrev <= holeLevel;
            if (holeLevel && !holePrev && spindleRun && mediaIn)
                idxCnt <= IDX_PULSE_CYC;
            else if (idxCnt != 32'h0000_0000)
                idxCnt <= idxCnt - 32'h0000_0001;
        end
    end

    // Outputs go high (released) unless selected
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            trackZero_n    <= 1'b1;
            indexSector_n  <= 1'b1;
            writeProtect_n <= 1'b1;
            readData_n     <= 1'b1;
        end
        else
        begin
            trackZero_n    <= !(selected && track == 8'h00);
            indexSector_n  <= !(selected && idxCnt != 32'h0000_0000);
            writeProtect_n <= !(selected && protect);
            readData_n     <= !(selected && readCnt != 8'h00);
        end
    end

    // AXI4-Lite slave: one write and one read at a time
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 8'h00;
            wData        <= 32'h0000_0000;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            ctrl         <= CTRL_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (awHeld && wHeld)
            begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr == REG_CTRL)
                begin
                    for (int b = 0; b < 4; b++)
                        if (wStrb[b])
                            ctrl[8*b +: 8] <= wData[8*b +: 8];
                    s_axi_bresp <= RESP_OKAY;
                end
                else
                    s_axi_bresp <= RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    drive_state_s st;

    assign st = '{spindleRun, writeEnable, selected && !cmd.writeGate,
                  upperHead, lampOn, track == 8'h00};

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL:   s_axi_rdata <= ctrl;
                REG_STATUS: s_axi_rdata <= {26'h0, st};
                REG_TRACK:  s_axi_rdata <= {24'h0, track};
                REG_EVENTS: s_axi_rdata <= {21'h0, ~clean};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule : diskette_drive_interface_control

// File: rtl/drive_iface_pkg.sv
// Purpose: Shared constants and carriers for the diskette drive interface
// Assumes: 20 MHz system clock
// Notes:   Register offsets are byte addresses on a 32-bit AXI4-Lite bus
package drive_iface_pkg;

    localparam int unsigned CLK_HZ       = 20_000_000;
    // Index/sector pulse low width, 4 ms nominal
    localparam int unsigned IDX_WIDTH_US = 4000;
    localparam int unsigned IDX_WIDTH_CYC = IDX_WIDTH_US * (CLK_HZ / 1_000_000);
    localparam int unsigned DATA_LOW_NS  = 1000;
    localparam int unsigned DATA_LOW_CYC = DATA_LOW_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned MIN_STEP_NS  = 1000;
    localparam int unsigned MIN_STEP_CYC =
        (MIN_STEP_NS + (1_000_000_000 / CLK_HZ) - 1) / (1_000_000_000 / CLK_HZ);

    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TRACK  = 8'h08;
    localparam logic [7:0] REG_EVENTS = 8'h0C;

    localparam int unsigned CTRL_SELECT_LSB = 0;
    localparam int unsigned CTRL_HARD_SECT  = 2;
    localparam int unsigned CTRL_WP_NOTCH   = 3;
    localparam int unsigned CTRL_MEDIA_IN   = 4;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0019;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Decoded drive commands as seen after sync, before select gating
    typedef struct packed {
        logic motorOn;
        logic dirIn;
        logic stepLow;
        logic writeGate;
        logic sideOne;
    } drive_cmd_s;

    // Head and media outputs reported to software
    typedef struct packed {
        logic       spindleRun;
        logic       writeEnable;
        logic       readEnable;
        logic       upperHead;
        logic       lampOn;
        logic       trackZero;
    } drive_state_s;

endpackage : drive_iface_pkg
